/* hdl/swg_regs.svh */
// Purpose: constants for the setpoint waveform generator
// Assumes: set values are 16-bit codes, full scale is the nominal value
// Notes:   times are counted in units of 0.1 ms
`ifndef SWG_REGS_SVH
`define SWG_REGS_SVH

// full-scale code of every set value
`define SWG_NOMINAL          16'hCCCC
`define SWG_FREQ_MIN         14'h0001
`define SWG_FREQ_MAX         14'h2710
// phase times in 0.1 ms units: 0.1 ms .. 36,000,000 ms
`define SWG_TIME_MIN         29'h0000001
`define SWG_TIME_MAX         29'h15752A00

`define SWG_CLK_PERIOD_NS    8
`define SWG_SAMPLE_NS        2000
`define SWG_TIME_UNIT_NS     100000
`define SWG_SAMPLE_CYC       (`SWG_SAMPLE_NS / `SWG_CLK_PERIOD_NS)
`define SWG_SAMPLES_PER_UNIT (`SWG_TIME_UNIT_NS / `SWG_SAMPLE_NS)

// phase step per sample = freq * 2^32 * sample time, scaled by 2^10
`define SWG_PHASE_MUL        24'h8637BD
`define SWG_PHASE_SHIFT      10

`endif

/* hdl/swg_pkg.sv */
// Purpose: types shared by the waveform generator modules
// Assumes: nothing beyond the constants header
// Notes:   all state records are packed so that '0 is the reset value
`default_nettype none
package swg_pkg;

    typedef enum logic [1:0] {SWG_SINE, SWG_TRI, SWG_RECT} swg_wave_t;
    typedef enum logic {SWG_VOLT, SWG_CURR} swg_target_t;
    typedef enum logic [1:0] {SWG_OFF, SWG_READY, SWG_RUN} swg_mode_t;
    typedef enum logic [1:0] {SWG_C_IDLE, SWG_C_WAVE, SWG_C_PWR} swg_calc_t;

    typedef struct packed {
        swg_wave_t   wave;
        swg_target_t target;
        logic [15:0] amp;
        logic [15:0] offset;
        logic [13:0] freq;
        logic [28:0] firstPhaseTime;
        logic [28:0] secondPhaseTime;
    } swg_cfg_t;

    typedef struct packed {
        logic [15:0] v;
        logic [15:0] i;
        logic [15:0] p;
    } swg_lim_t;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic [5:0]  cnt;
        logic [39:0] den;
        logic [40:0] rem;
        logic [55:0] quo;
    } swg_div_t;

    typedef struct packed {
        swg_mode_t   mode;
        swg_calc_t   calc;
        swg_cfg_t    cfg;
        logic        cfgLoaded;
        swg_lim_t    lim;
        swg_lim_t    slaveLim;
        swg_lim_t    setp;
        logic        outputOn;
        logic        screenActive;
        logic [7:0]  sampCnt;
        logic [31:0] phase;
        logic [35:0] elapsed;
        logic        seg;
        logic        calcRise;
        logic [15:0] gen;
        logic        rejectPulse;
        logic        alarmPulse;
        logic        slaveStrobe;
    } swg_state_t;

endpackage

`default_nettype wire

/* hdl/swg_divider.sv */
// Purpose: serial unsigned divider, one quotient bit per clock
// Assumes: start is only honoured while idle
// Notes:   56 cycles from start to done; divide by zero gives all ones
`timescale 1ns/1ps
`default_nettype none

module swg_divider (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // request
    input  wire logic        start,
    input  wire logic [55:0] dividend,
    input  wire logic [39:0] divisor,
    // answer
    output logic             done,
    output logic [55:0]      quotient
);
    import swg_pkg::*;

    swg_div_t s;
    swg_div_t n;

    always_comb begin
        logic [40:0] trial;
        trial = '0;
        n = s;
        n.done = 1'b0;
        if (!s.busy) begin
            if (start) begin
                n.busy = 1'b1;
                n.cnt  = 6'h38;
                n.quo  = dividend;
                n.rem  = '0;
                n.den  = divisor;
            end
        end else begin
            trial = {s.rem[39:0], s.quo[55]};
            n.quo = {s.quo[54:0], 1'b0};
            if (trial >= {1'b0, s.den}) begin
                n.rem    = trial - {1'b0, s.den};
                n.quo[0] = 1'b1;
            end else begin
                n.rem = trial;
            end
            n.cnt = s.cnt - 6'h01;
            if (s.cnt == 6'h01) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign done     = s.done;
    assign quotient = s.quo;

endmodule

`default_nettype wire

/* hdl/swg_generator.sv */
// Purpose: drives one set value of a DC supply with sine, triangle or
//          rectangle, the other set values staying static as limits
// Assumes: command inputs are one-cycle pulses synchronous to clk
// Notes:   one sample every 2 us, power clamp recomputed per sample
// Operation
// - Resistance regulation mode blocks all configuration and all running.
// - Set values are quantised to a 52428-step full scale; staircases follow.
// - Waveform drives only voltage or current; others stay static limits.
// - Modulated quantity is clamped so output power stays within the power value.
// - As master, forward the global voltage, current, power limits to slaves.
// - Function and target are accepted from the panel only with output off; their parameters also with output on.
// - Static global values are driven before and after a run.
// - Entering the run screen switches output on with global values.
// - Run starts on start command, or on/off button while output off.
// - Stop command ends waveform, output stays on at global values.
// - On/off button during a run ends waveform and switches output off.
// - Any alarm or protection trip aborts, switches output off, reports it.
// - Sine frequency 1 to 10000 Hz, amplitude zero to nominal value.
// - Sine offset is the zero line and must not be below amplitude.
// - Triangle offset is the foot, peak is offset plus amplitude.
// - Triangle rise and fall times each 0.1 ms to 36,000,000 ms.
// - Rectangle holds upper level first time, lower level second time.
// - Rectangle low is offset, high offset plus amplitude, within nominal.
// - Global values and function parameters may change during a run.
`timescale 1ns/1ps
`default_nettype none
`include "swg_regs.svh"

module swg_generator (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // configuration
    input  wire logic              resistanceModeActive,
    input  wire logic              cfgWrite,
    input  wire swg_pkg::swg_cfg_t cfgIn,
    input  wire logic              limWrite,
    input  wire swg_pkg::swg_lim_t limIn,
    // operator commands
    input  wire logic              enterRunScreen,
    input  wire logic              leaveRunScreen,
    input  wire logic              startCmd,
    input  wire logic              stopCmd,
    input  wire logic              onOffButton,
    // protection
    input  wire logic              deviceAlarm,
    input  wire logic              overpowerProtection,
    input  wire logic              overcurrentProtection,
    input  wire logic              eventAlarm,
    // master-slave system
    input  wire logic              isMaster,
    output swg_pkg::swg_lim_t      slaveLim,
    output logic                   slaveLimStrobe,
    // power stage
    output swg_pkg::swg_lim_t      setpoint,
    output logic                   outputOn,
    // status
    output logic                   running,
    output logic                   cfgRejected,
    output logic                   alarmReport
);
    import swg_pkg::*;

    swg_state_t  s;
    swg_state_t  n;
    logic        divGo;
    logic [55:0] divA;
    logic [39:0] divB;
    logic        divDone;
    logic [55:0] divQ;

    function automatic logic fitsNominal(logic [15:0] off, logic [15:0] amp);
        return ({1'b0, off} + {1'b0, amp}) <= {1'b0, `SWG_NOMINAL};
    endfunction

    function automatic logic timeOk(logic [28:0] t);
        return (t >= `SWG_TIME_MIN) && (t <= `SWG_TIME_MAX);
    endfunction

    function automatic logic cfgValid(swg_cfg_t c);
        logic ok;
        ok = (c.amp <= `SWG_NOMINAL);
        case (c.wave)
            SWG_SINE: begin
                ok = ok && (c.freq >= `SWG_FREQ_MIN) && (c.freq <= `SWG_FREQ_MAX)
                     && (c.offset >= c.amp) && fitsNominal(c.offset, c.amp);
            end
            SWG_TRI, SWG_RECT: begin
                ok = ok && fitsNominal(c.offset, c.amp)
                     && timeOk(c.firstPhaseTime) && timeOk(c.secondPhaseTime);
            end
            default: begin
                ok = 1'b0;
            end
        endcase
        return ok;
    endfunction

    function automatic logic limValid(swg_lim_t l);
        return (l.v <= `SWG_NOMINAL) && (l.i <= `SWG_NOMINAL) && (l.p <= `SWG_NOMINAL);
    endfunction

    function automatic logic [35:0] toSamples(logic [28:0] t);
        return 36'(t) * 36'(`SWG_SAMPLES_PER_UNIT);
    endfunction

    // anything above full scale is pinned there
    function automatic logic [15:0] sat16(logic [55:0] v);
        return (v > 56'(`SWG_NOMINAL)) ? `SWG_NOMINAL : v[15:0];
    endfunction

    function automatic logic [15:0] scaleFrac(logic [15:0] amp, logic [15:0] frac);
        logic [31:0] prod;
        prod = 32'(amp) * 32'(frac);
        return prod[30:15];
    endfunction

    function automatic swg_state_t runStart(swg_state_t st);
        swg_state_t r;
        r = st;
        r.mode    = SWG_RUN;
        r.calc    = SWG_C_IDLE;
        r.phase   = '0;
        r.elapsed = '0;
        r.seg     = 1'b1;
        return r;
    endfunction

    swg_divider u_div (
        .clk      (clk),
        .rst      (rst),
        .start    (divGo),
        .dividend (divA),
        .divisor  (divB),
        .done     (divDone),
        .quotient (divQ)
    );

    always_comb begin
        logic        anyAlarm;
        logic        blocked;
        logic        sampStrobe;
        logic [35:0] durS;
        logic [15:0] frac;
        logic [15:0] mag;
        logic [14:0] x;
        logic [31:0] parab;
        logic [37:0] inc;
        logic [15:0] other;
        logic [15:0] limQ;
        logic [15:0] tgt;
        anyAlarm   = deviceAlarm | overpowerProtection | overcurrentProtection | eventAlarm;
        blocked    = resistanceModeActive | anyAlarm;
        sampStrobe = (s.sampCnt == 8'(`SWG_SAMPLE_CYC - 1));
        durS  = '0;
        frac  = '0;
        mag   = '0;
        x     = '0;
        parab = '0;
        inc   = '0;
        other = '0;
        limQ  = '0;
        tgt   = '0;
        divGo = 1'b0;
        divA  = '0;
        divB  = '0;
        n = s;
        n.rejectPulse = 1'b0;
        n.alarmPulse  = 1'b0;
        n.slaveStrobe = 1'b0;
        n.sampCnt = sampStrobe ? 8'h00 : s.sampCnt + 8'h01;

        // global values may change at any time outside resistance mode, also during a run
        if (limWrite) begin
            if (!resistanceModeActive && limValid(limIn)) begin
                n.lim = limIn;
            end else begin
                n.rejectPulse = 1'b1;
            end
        end

        // with output on only the parameters of the running shape may change
        if (cfgWrite) begin
            if (!resistanceModeActive && cfgValid(cfgIn)
                && (!s.outputOn
                    || (cfgIn.wave == s.cfg.wave && cfgIn.target == s.cfg.target))) begin
                n.cfg       = cfgIn;
                n.cfgLoaded = 1'b1;
            end else begin
                n.rejectPulse = 1'b1;
            end
        end

        case (s.mode)
            SWG_OFF: begin
                if (enterRunScreen && s.cfgLoaded && !blocked) begin
                    n.outputOn     = 1'b1;
                    n.screenActive = 1'b1;
                    n.mode         = SWG_READY;
                end else if (onOffButton && s.screenActive && !blocked) begin
                    n = runStart(n);
                    n.outputOn = 1'b1;
                end else if (leaveRunScreen) begin
                    n.screenActive = 1'b0;
                end
            end
            SWG_READY: begin
                if (startCmd && !blocked) begin
                    n = runStart(n);
                end else if (onOffButton) begin
                    n.outputOn = 1'b0;
                    n.mode     = SWG_OFF;
                end
            end
            SWG_RUN: begin
                if (onOffButton) begin
                    n.outputOn = 1'b0;
                    n.mode     = SWG_OFF;
                end else if (stopCmd || resistanceModeActive) begin
                    n.mode = SWG_READY;
                end
            end
            default: begin
                n.mode = SWG_OFF;
            end
        endcase

        // protection wins over every command
        if (anyAlarm && (s.outputOn || s.mode != SWG_OFF)) begin
            n.outputOn   = 1'b0;
            n.mode       = SWG_OFF;
            n.alarmPulse = 1'b1;
        end

        if (isMaster && (n.lim != s.slaveLim || (n.outputOn && !s.outputOn))) begin
            n.slaveLim    = n.lim;
            n.slaveStrobe = 1'b1;
        end

        other = (s.cfg.target == SWG_VOLT) ? s.lim.i : s.lim.v;

        if (n.mode != SWG_RUN) begin
            n.setp = n.lim;
            n.calc = SWG_C_IDLE;
        end else if (s.mode == SWG_RUN) begin
            // the two static values follow the globals live
            if (s.cfg.target == SWG_VOLT) begin
                n.setp.i = n.lim.i;
            end else begin
                n.setp.v = n.lim.v;
            end
            n.setp.p = n.lim.p;
            case (s.calc)
                SWG_C_IDLE: begin
                    if (sampStrobe) begin
                        durS = toSamples(s.seg ? s.cfg.firstPhaseTime : s.cfg.secondPhaseTime);
                        // periodic: segments alternate until stopped
                        if (s.elapsed + 36'h1 >= durS) begin
                            n.elapsed = '0;
                            n.seg     = ~s.seg;
                        end else begin
                            n.elapsed = s.elapsed + 36'h1;
                        end
                        inc = 38'(s.cfg.freq) * 38'(`SWG_PHASE_MUL);
                        n.phase = s.phase + 32'(inc >> `SWG_PHASE_SHIFT);
                        n.calcRise = s.seg;
                        case (s.cfg.wave)
                            SWG_SINE: begin
                                // parabola per half period approximates the sine
                                x     = s.phase[30:16];
                                parab = 32'(x) * (32'h0000_8000 - 32'(x));
                                frac  = parab[28:13];
                                mag   = scaleFrac(s.cfg.amp, frac);
                                n.gen = s.phase[31] ? s.cfg.offset - mag
                                                    : sat16(56'(s.cfg.offset) + 56'(mag));
                                n.calc = SWG_C_PWR;
                            end
                            SWG_TRI: begin
                                divGo  = 1'b1;
                                divA   = 56'(s.elapsed) * 56'(s.cfg.amp);
                                divB   = 40'(durS);
                                n.calc = SWG_C_WAVE;
                            end
                            SWG_RECT: begin
                                n.gen = s.seg ? sat16(56'(s.cfg.offset) + 56'(s.cfg.amp))
                                              : s.cfg.offset;
                                n.calc = SWG_C_PWR;
                            end
                            default: begin
                                n.gen = s.cfg.offset;
                            end
                        endcase
                    end
                end
                SWG_C_WAVE: begin
                    if (divDone) begin
                        n.gen = s.calcRise ? sat16(56'(s.cfg.offset) + 56'(divQ[15:0]))
                                           : sat16(56'(s.cfg.offset) + 56'(s.cfg.amp)
                                                   - 56'(divQ[15:0]));
                        n.calc = SWG_C_PWR;
                    end
                end
                SWG_C_PWR: begin
                    if (divDone) begin
                        limQ = sat16(divQ);
                        tgt  = (s.gen > limQ) ? limQ : s.gen;
                        if (s.cfg.target == SWG_VOLT) begin
                            n.setp.v = tgt;
                        end else begin
                            n.setp.i = tgt;
                        end
                        n.calc = SWG_C_IDLE;
                    end
                end
                default: begin
                    n.calc = SWG_C_IDLE;
                end
            endcase
            // power limit as the other static value allows; start on entry to the step
            if (n.calc == SWG_C_PWR && s.calc != SWG_C_PWR) begin
                divGo = 1'b1;
                divA  = 56'(s.lim.p) * 56'(`SWG_NOMINAL);
                divB  = 40'(other);
            end
        end else begin
            n.setp = n.lim;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign setpoint       = s.setp;
    assign outputOn       = s.outputOn;
    assign running        = (s.mode == SWG_RUN);
    assign cfgRejected    = s.rejectPulse;
    assign alarmReport    = s.alarmPulse;
    assign slaveLim       = s.slaveLim;
    assign slaveLimStrobe = s.slaveStrobe;

endmodule

`default_nettype wire

/* dv/swg_asserts.sv */
// Purpose: port-level checks of the setpoint waveform generator
// Assumes: command and write inputs are one-cycle pulses
// Notes:   levels and clamp in a run are judged by the bench
`timescale 1ns/1ps
`default_nettype none
`include "swg_regs.svh"

module swg_asserts (
    // clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // configuration and commands
    input wire logic              resistanceModeActive,
    input wire logic              cfgWrite,
    input wire swg_pkg::swg_cfg_t cfgIn,
    input wire logic              limWrite,
    input wire swg_pkg::swg_lim_t limIn,
    input wire logic              startCmd,
    input wire logic              stopCmd,
    input wire logic              onOffButton,
    input wire logic              isMaster,
    // protection
    input wire logic              deviceAlarm,
    input wire logic              overpowerProtection,
    input wire logic              overcurrentProtection,
    input wire logic              eventAlarm,
    // generator outputs
    input wire swg_pkg::swg_lim_t slaveLim,
    input wire logic              slaveLimStrobe,
    input wire swg_pkg::swg_lim_t setpoint,
    input wire logic              outputOn,
    input wire logic              running,
    input wire logic              cfgRejected,
    input wire logic              alarmReport
);
    import swg_pkg::*;

    logic anyAlarm;
    logic badTime;
    assign anyAlarm = deviceAlarm | overpowerProtection | overcurrentProtection | eventAlarm;
    assign badTime = cfgIn.firstPhaseTime < `SWG_TIME_MIN || cfgIn.firstPhaseTime > `SWG_TIME_MAX
        || cfgIn.secondPhaseTime < `SWG_TIME_MIN || cfgIn.secondPhaseTime > `SWG_TIME_MAX;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_lim_ok;
        limWrite && !resistanceModeActive && limIn.v <= `SWG_NOMINAL
            && limIn.i <= `SWG_NOMINAL && limIn.p <= `SWG_NOMINAL;
    endsequence
    // a run starting in the same cycle would modulate one field
    sequence s_idle_write;
        !running && !anyAlarm && !startCmd && !onOffButton ##0 s_lim_ok;
    endsequence

    a_resist_refuse: assert property (cfgWrite && resistanceModeActive
        |=> cfgRejected)
        else $error("config taken in resistance mode");
    a_amp_refuse: assert property (cfgWrite && cfgIn.amp > `SWG_NOMINAL
        |=> cfgRejected)
        else $error("oversized amplitude taken");
    a_sine_offset: assert property (cfgWrite && cfgIn.wave == SWG_SINE
        && cfgIn.offset < cfgIn.amp |=> cfgRejected)
        else $error("sine offset below amplitude taken");
    a_sine_freq: assert property (cfgWrite && cfgIn.wave == SWG_SINE
        && (cfgIn.freq < `SWG_FREQ_MIN || cfgIn.freq > `SWG_FREQ_MAX) |=> cfgRejected)
        else $error("sine frequency out of range taken");
    a_time_refuse: assert property (cfgWrite && cfgIn.wave != SWG_SINE && badTime
        |=> cfgRejected)
        else $error("phase time out of range taken");
    a_lim_static: assert property (s_idle_write |=> setpoint == $past(limIn))
        else $error("static values not applied");
    a_slave_copy: assert property (isMaster && limIn != slaveLim ##0 s_lim_ok
        |=> slaveLimStrobe && slaveLim == $past(limIn))
        else $error("limits not forwarded to slaves");
    a_alarm_abort: assert property (outputOn && anyAlarm
        |=> !outputOn && !running && alarmReport)
        else $error("alarm did not abort the run");
    a_stop_keeps: assert property (running && stopCmd && !onOffButton && !anyAlarm
        && !resistanceModeActive |=> !running && outputOn)
        else $error("stop did not keep output on");
    a_onoff_stops: assert property (running && onOffButton && !anyAlarm
        |=> !outputOn && !running)
        else $error("on/off did not end the run");
    a_run_output: assert property (running |-> outputOn)
        else $error("running with output off");
endmodule

bind swg_generator swg_asserts u_chk (.*);
`default_nettype wire

/* dv/swg_power_stage.sv */
// Purpose: behavioural power stage behind the generator
// Assumes: trips are commanded by the bench
// Notes:   a trip reaches the generator one cycle after the command
`timescale 1ns/1ps
`default_nettype none

module swg_power_stage (
    // clock and reset
    input  wire logic  clk,
    input  wire logic  rst,
    // bench commands
    input  wire logic  tripOc,
    input  wire logic  tripOp,
    // protection towards the generator
    output logic       overcurrentProtection,
    output logic       overpowerProtection
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overcurrentProtection <= 1'b0;
            overpowerProtection <= 1'b0;
        end else begin
            overcurrentProtection <= tripOc;
            overpowerProtection <= tripOp;
        end
    end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Purpose: self-checking bench for the setpoint waveform generator
// Assumes: inputs change 1 ns after the rising edge
// Notes:   phase times of one unit hold each rectangle level 12500 cycles
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import swg_pkg::*;
    localparam int ENTER = 0, LEAVE = 1, START = 2, STOP = 3, ONOFF = 4;
    logic     clk = 1'b0;
    logic     rst = 1'b1;
    logic     resistanceModeActive, cfgWrite, limWrite, isMaster, tripOc, tripOp;
    logic     enterRunScreen, leaveRunScreen, startCmd, stopCmd, onOffButton;
    logic     deviceAlarm, eventAlarm, overpowerProtection, overcurrentProtection;
    logic     slaveLimStrobe, outputOn, running, cfgRejected, alarmReport;
    swg_cfg_t cfgIn, good;
    swg_lim_t limIn, slaveLim, setpoint, glob;
    int       n_errors = 0;
    int       tests_run = 0;

    always #4 clk = ~clk;

    swg_generator   DUT (.*);
    swg_power_stage u_stage (.*);

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // leading edge: a pulse is never lowered and raised in one step
    task automatic cmd(input int w);
        tick();
        {enterRunScreen, leaveRunScreen, startCmd, stopCmd, onOffButton} = 5'h10 >> w;
        tick();
        {enterRunScreen, leaveRunScreen, startCmd, stopCmd, onOffButton} = 5'h00;
    endtask

    task automatic do_cfg(input swg_cfg_t c, input logic expRej);
        tick();
        cfgIn = c;
        cfgWrite = 1'b1;
        tick();
        cfgWrite = 1'b0;
        chk("cfgRejected", 48'(expRej), 48'(cfgRejected));
    endtask

    task automatic do_lim(input swg_lim_t l);
        tick();
        limIn = l;
        limWrite = 1'b1;
        tick();
        limWrite = 1'b0;
    endtask

    // bound covers a full rectangle period plus slack
    task automatic wait_v(input logic [15:0] lvl);
        int k;
        for (k = 0; k < 30000 && setpoint.v !== lvl; k++)
            tick();
        chk("setpoint.v", 48'(lvl), 48'(setpoint.v));
        if (k == 30000)
            report_and_stop();
    endtask

    task automatic sc_refuse();
        swg_cfg_t c;
        resistanceModeActive = 1'b1;
        do_cfg(good, 1'b1);
        resistanceModeActive = 1'b0;
        c = good;
        c.wave = SWG_SINE;
        c.offset = 16'h0FFF;
        do_cfg(c, 1'b1);
        c.offset = 16'h1000;
        c.freq = 14'h0000;
        do_cfg(c, 1'b1);
        c.freq = 14'h2711;
        do_cfg(c, 1'b1);
        c.freq = 14'h2710;
        do_cfg(c, 1'b0);
        c = good;
        c.firstPhaseTime = 29'h0;
        do_cfg(c, 1'b1);
        c = good;
        c.wave = SWG_TRI;
        c.secondPhaseTime = 29'h15752A01;
        do_cfg(c, 1'b1);
        c = good;
        c.offset = 16'hBCCD;
        do_cfg(c, 1'b1);
        c.offset = 16'hBCCC;
        do_cfg(c, 1'b0);
        c.amp = 16'hCCCD;
        c.offset = 16'h0000;
        do_cfg(c, 1'b1);
        do_cfg(good, 1'b0);
        do_lim('{v: 16'hCCCD, i: 16'h0000, p: 16'h0000});
        chk("limit refused", 48'h1, 48'(cfgRejected));
    endtask

    task automatic sc_run();
        swg_cfg_t c;
        swg_lim_t lp;
        do_lim(glob);
        chk("setpoint", glob, setpoint);
        chk("slaveLim", glob, slaveLim);
        chk("slaveLimStrobe", 48'h1, 48'(slaveLimStrobe));
        cmd(ENTER);
        chk("outputOn", 48'h1, 48'(outputOn));
        chk("setpoint", glob, setpoint);
        c = good;
        c.wave = SWG_TRI;
        do_cfg(c, 1'b1);
        cmd(START);
        chk("running", 48'h1, 48'(running));
        wait_v(16'h1800);
        chk("setpoint.i", 48'(glob.i), 48'(setpoint.i));
        wait_v(16'h0800);
        lp = glob;
        lp.p = 16'h0800;
        do_lim(lp);
        chk("setpoint.p", 48'h0800, 48'(setpoint.p));
        // power limit now caps the high level at 0x1000
        wait_v(16'h1000);
        cmd(STOP);
        chk("run and output", 48'h1, {46'h0, running, outputOn});
        chk("setpoint", lp, setpoint);
        cmd(ONOFF);
        chk("outputOn", 48'h0, 48'(outputOn));
        cmd(ONOFF);
        chk("run and output", 48'h3, {46'h0, running, outputOn});
        cmd(ONOFF);
        chk("run and output", 48'h0, {46'h0, running, outputOn});
        isMaster = 1'b0;
        do_lim(glob);
        chk("slaveLimStrobe", 48'h0, 48'(slaveLimStrobe));
        isMaster = 1'b1;
        cmd(LEAVE);
    endtask

    task automatic sc_alarm();
        int k;
        for (int a = 0; a < 4; a++) begin
            cmd(ENTER);
            cmd(START);
            {deviceAlarm, eventAlarm, tripOc, tripOp} = 4'h8 >> a;
            for (k = 0; k < 5 && outputOn; k++)
                tick();
            chk("run and output", 48'h0, {46'h0, running, outputOn});
            chk("alarmReport", 48'h1, 48'(alarmReport));
            {deviceAlarm, eventAlarm, tripOc, tripOp} = 4'h0;
            if (k == 5)
                report_and_stop();
        end
    endtask

    initial begin
        {resistanceModeActive, cfgWrite, limWrite, deviceAlarm, eventAlarm} = '0;
        {tripOc, tripOp, enterRunScreen, leaveRunScreen, startCmd, stopCmd, onOffButton} = '0;
        isMaster = 1'b1;
        cfgIn = '0;
        limIn = '0;
        good = '{wave: SWG_RECT, target: SWG_VOLT, amp: 16'h1000, offset: 16'h0800,
                 freq: 14'h0001, firstPhaseTime: 29'h1, secondPhaseTime: 29'h1};
        glob = '{v: 16'h0400, i: 16'h6666, p: 16'hCCCC};
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        sc_refuse();
        sc_run();
        sc_alarm();
        report_and_stop();
    end
endmodule
`default_nettype wire
